// *** logic/ieee_consts.vh ***
// Purpose: Shared constants for the instrument-side bus addressing block.
// Assumes: Included by bare name from the design files of this block.
// Notes: Offsets are APB byte addresses; codes are seven-bit bus command values.
`ifndef IEEE_CONSTS_VH
`define IEEE_CONSTS_VH

// Register map (byte addresses on APB).
`define IEEE_CFG_OFS 12'h000
`define IEEE_STAT_OFS 12'h004
`define IEEE_MEAS_OFS 12'h008

// Configuration field: bus address in bits 4:0, shipped value 28.
`define IEEE_ADDR_LSB 0
`define IEEE_ADDR_W 5
`define IEEE_ADDR_RST 5'h1C

// Status field positions.
`define IEEE_ST_REMOTE 0
`define IEEE_ST_ADDRESSED 1
`define IEEE_ST_LISTEN 2
`define IEEE_ST_TALK 3
`define IEEE_ST_LOCKOUT 4
`define IEEE_ST_MEAS_LSB 8

// Address group prefixes and universal / addressed commands (ATN true).
`define IEEE_LAG_PFX 2'h1
`define IEEE_TAG_PFX 2'h2
`define IEEE_CMD_UNL 7'h3F
`define IEEE_CMD_UNT 7'h5F
`define IEEE_CMD_GTL 7'h01
`define IEEE_CMD_SDC 7'h04
`define IEEE_CMD_LLO 7'h11
`define IEEE_CMD_DCL 7'h14

// Measurement selection codes, equal to the digit after the M character.
`define IEEE_MEAS_W 2
`define IEEE_MEAS_AC 2'h1
`define IEEE_MEAS_SINAD 2'h2
`define IEEE_MEAS_DIST 2'h3
`define IEEE_MEAS_RST 2'h1

// Command characters received as data.
`define IEEE_CH_M 7'h4D
`define IEEE_CH_ZERO 4'h3

// Result message: sign, five mantissa digits, E, sign, two exponent digits, LF.
`define IEEE_MSG_LEN 4'hB
`define IEEE_ERR_MANT 20'h90096
`define IEEE_ERR_EXP 8'h05

`endif

// *** logic/ieee_talk_ram.v ***
// Purpose: Small buffer that holds the formatted result bytes for talking.
// Assumes: One write port and one read port on the same clock.
// Notes: Read data come out of a register, one cycle after rd_en.
module ieee_talk_ram #(
  parameter WIDTH = 8,
  parameter AW = 4
) (
  input wire pclk,
  input wire presetn,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);

  // Storage array; contents need no reset because they are written before use.
  reg [WIDTH-1:0] mem [0:(1<<AW)-1];

  // Write port.
  always @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read port, cleared at reset so the output is never unknown.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= {WIDTH{1'b0}};
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// *** logic/ieee_addr.v ***
// Purpose: Instrument-side bus addressing, remote/local control and data messages.
// Assumes: Bus bytes arrive already handshaken, one pulse per byte, synchronous to pclk.
// Notes: Serial poll, abort and handshake timing live outside this block.
//
// Design decisions made here: the placing of the registers and the APB register port.
`include "ieee_consts.vh"

// How it works
// - Own listen address without REN: addressed, local
// - Another device's address unaddresses this device
// - REN plus listen address enters remote, addressed
// - REN first, remote only once addressed
// - Addressed Local message returns local, stays addressed
// - Local key returns local unless locked out
// - Lockout in remote disables all keys including local key
// - REN false clears lockout, returns local
// - Talk address sends result, no remote
// - Distortion without signal reports error 96
// - Listened M2 selects SINAD, lights lamp
// - All seven low data bits decoded
// - Clear message resets selection to AC level
// - Bus address defaults to 28
module ieee_addr (
  input wire pclk,
  input wire presetn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // Bus side, bytes already accepted by the handshake logic.
  input wire ren,
  input wire atn,
  input wire bus_byte_valid,
  input wire [7:0] bus_byte_data,
  input wire talk_take,
  output wire talk_valid,
  output wire [7:0] talk_data,
  output reg talk_last,
  // Front panel.
  input wire local_key,
  input wire ac_level_key,
  input wire sinad_key,
  input wire distortion_select_key,
  output wire remote_lamp,
  output wire addressed_lamp,
  output wire ac_level_lamp,
  output wire sinad_lamp,
  output wire distortion_lamp,
  // Measurement engine.
  input wire signal_absent,
  input wire [19:0] result_mant,
  input wire [7:0] result_exp,
  output wire [1:0] meas_select
);

  // Talk sequencer states.
  localparam TK_IDLE = 2'h0;
  localparam TK_FILL = 2'h1;
  localparam TK_FETCH = 2'h2;
  localparam TK_SHOW = 2'h3;

  reg [4:0] bus_addr_r; // Configured bus address.
  reg listen_r; // Addressed to listen.
  reg talk_r; // Addressed to talk.
  reg remote_r; // Remote control.
  reg lockout_r; // Local lockout in force.
  reg [1:0] meas_r; // Selected measurement.
  reg got_m_r; // Last data byte was the M character.
  reg [1:0] tk_state_r; // Talk sequencer state.
  reg [3:0] fill_idx_r; // Byte being written into the buffer.
  reg [3:0] rd_idx_r; // Byte being sent.
  reg err_snap_r; // Error condition latched for this message.
  reg [19:0] mant_snap_r; // Mantissa latched for this message.
  reg [7:0] exp_snap_r; // Exponent latched for this message.
  wire [7:0] ram_q; // Buffer read data.

  // Seven-bit command/data value; the eighth line carries no meaning here.
  wire [6:0] cmd = bus_byte_data[6:0];
  wire cmd_ev = bus_byte_valid && atn;
  wire data_ev = bus_byte_valid && !atn;

  // Address match helper, used for both listen and talk groups.
  function addr_is;
    input [6:0] c;
    input [1:0] pfx;
    input [4:0] a;
    begin
      addr_is = (c[6:5] == pfx) && (c[4:0] == a);
    end
  endfunction

  // Formats one result character. Error condition forces the error mantissa.
  function [7:0] fmt_byte;
    input [3:0] idx;
    input [19:0] mant;
    input [7:0] ex;
    reg [3:0] d;
    begin
      d = 4'h0;
      fmt_byte = 8'h2B;
      case (idx)
        4'h0: fmt_byte = 8'h2B;
        4'h1: d = mant[19:16];
        4'h2: d = mant[15:12];
        4'h3: d = mant[11:8];
        4'h4: d = mant[7:4];
        4'h5: d = mant[3:0];
        4'h6: fmt_byte = 8'h45;
        4'h7: fmt_byte = 8'h2B;
        4'h8: d = ex[7:4];
        4'h9: d = ex[3:0];
        4'hA: fmt_byte = 8'h0A;
        default: fmt_byte = 8'h0A;
      endcase
      if ((idx >= 4'h1 && idx <= 4'h5) || idx == 4'h8 || idx == 4'h9) begin
        fmt_byte = {`IEEE_CH_ZERO, d};
      end
    end
  endfunction

  wire my_listen = cmd_ev && addr_is(cmd, `IEEE_LAG_PFX, bus_addr_r);
  wire my_talk = cmd_ev && addr_is(cmd, `IEEE_TAG_PFX, bus_addr_r);
  // Any other primary address, excluding the unlisten/untalk codes.
  wire other_addr = cmd_ev && !my_listen && !my_talk &&
                    (cmd[6:5] == `IEEE_LAG_PFX || cmd[6:5] == `IEEE_TAG_PFX) &&
                    cmd != `IEEE_CMD_UNL && cmd != `IEEE_CMD_UNT;
  // Keys are dead while the lockout holds in remote, the local key included.
  wire keys_live = !(remote_r && lockout_r);
  wire clear_ev = cmd_ev && (cmd == `IEEE_CMD_DCL ||
                  (cmd == `IEEE_CMD_SDC && listen_r));

  // Addressing state. REN falling has highest priority so a late address
  // cannot leave the device stuck in remote.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      listen_r <= 1'b0;
      talk_r <= 1'b0;
      remote_r <= 1'b0;
      lockout_r <= 1'b0;
    end else begin
      if (my_listen) begin
        listen_r <= 1'b1;
      end else if (other_addr || (cmd_ev && cmd == `IEEE_CMD_UNL)) begin
        listen_r <= 1'b0;
      end
      if (my_talk) begin
        talk_r <= 1'b1;
      end else if (other_addr || (cmd_ev && cmd == `IEEE_CMD_UNT)) begin
        talk_r <= 1'b0;
      end
      if (!ren) begin
        remote_r <= 1'b0;
        lockout_r <= 1'b0;
      end else begin
        if (my_listen) begin
          remote_r <= 1'b1;
        end else if (cmd_ev && cmd == `IEEE_CMD_GTL && listen_r) begin
          remote_r <= 1'b0;
        end else if (local_key && keys_live) begin
          remote_r <= 1'b0;
        end
        if (cmd_ev && cmd == `IEEE_CMD_LLO) begin
          lockout_r <= 1'b1;
        end
      end
    end
  end

  // Measurement selection from listened commands, clear and the front panel.
  // Front-panel selection keys act only in local control.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_r <= `IEEE_MEAS_RST;
      got_m_r <= 1'b0;
    end else begin
      if (clear_ev) begin
        meas_r <= `IEEE_MEAS_AC;
        got_m_r <= 1'b0;
      end else if (data_ev && listen_r) begin
        got_m_r <= (cmd == `IEEE_CH_M);
        if (got_m_r && {1'b0, cmd[6:4]} == `IEEE_CH_ZERO && cmd[3:0] >= 4'h1 &&
            cmd[3:0] <= 4'h3) begin
          meas_r <= cmd[1:0];
        end
      end else if (!remote_r && keys_live) begin
        if (ac_level_key) begin
          meas_r <= `IEEE_MEAS_AC;
        end else if (sinad_key) begin
          meas_r <= `IEEE_MEAS_SINAD;
        end else if (distortion_select_key) begin
          meas_r <= `IEEE_MEAS_DIST;
        end
      end
    end
  end

  // Talk sequencer: latch the result, format it into the buffer, then hand
  // it out one byte per take. Losing the talk address aborts the message.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tk_state_r <= TK_IDLE;
      fill_idx_r <= 4'h0;
      rd_idx_r <= 4'h0;
      err_snap_r <= 1'b0;
      mant_snap_r <= 20'h00000;
      exp_snap_r <= 8'h00;
      talk_last <= 1'b0;
    end else if (!talk_r && !my_talk) begin
      tk_state_r <= TK_IDLE;
      talk_last <= 1'b0;
    end else begin
      case (tk_state_r)
        TK_IDLE: begin
          if (my_talk) begin
            err_snap_r <= (meas_r == `IEEE_MEAS_DIST) && signal_absent;
            mant_snap_r <= result_mant;
            exp_snap_r <= result_exp;
            fill_idx_r <= 4'h0;
            rd_idx_r <= 4'h0;
            tk_state_r <= TK_FILL;
          end
        end
        TK_FILL: begin
          fill_idx_r <= fill_idx_r + 4'h1;
          if (fill_idx_r == `IEEE_MSG_LEN - 4'h1) begin
            tk_state_r <= TK_FETCH;
          end
        end
        TK_FETCH: begin
          talk_last <= (rd_idx_r == `IEEE_MSG_LEN - 4'h1);
          tk_state_r <= TK_SHOW;
        end
        TK_SHOW: begin
          if (talk_take) begin
            rd_idx_r <= rd_idx_r + 4'h1;
            tk_state_r <= talk_last ? TK_IDLE : TK_FETCH;
          end
        end
        default: tk_state_r <= TK_IDLE;
      endcase
    end
  end

  // Error code 96 is sent as mantissa 90096 with exponent 5.
  wire [19:0] tx_mant = err_snap_r ? `IEEE_ERR_MANT : mant_snap_r;
  wire [7:0] tx_exp = err_snap_r ? `IEEE_ERR_EXP : exp_snap_r;

  ieee_talk_ram #(
    .WIDTH(8),
    .AW(4)
  ) u_ram (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(tk_state_r == TK_FILL),
    .wr_addr(fill_idx_r),
    .wr_data(fmt_byte(fill_idx_r, tx_mant, tx_exp)),
    .rd_en(tk_state_r == TK_FETCH),
    .rd_addr(rd_idx_r),
    .rd_data(ram_q)
  );

  assign talk_valid = (tk_state_r == TK_SHOW);
  assign talk_data = ram_q;

  // APB slave: zero wait states; unmapped addresses answer with an error.
  wire apb_acc = psel && penable;
  wire hit_cfg = (paddr == `IEEE_CFG_OFS);
  wire hit_stat = (paddr == `IEEE_STAT_OFS);
  wire hit_meas = (paddr == `IEEE_MEAS_OFS);
  assign pready = 1'b1;
  assign pslverr = apb_acc && !(hit_cfg || hit_stat || hit_meas);

  // Configuration write; the address takes effect on the next bus byte.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_addr_r <= `IEEE_ADDR_RST;
    end else if (apb_acc && pwrite && hit_cfg) begin
      bus_addr_r <= pwdata[`IEEE_ADDR_LSB +: `IEEE_ADDR_W];
    end
  end

  // Read data registered at the end of the setup phase.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      if (hit_cfg) begin
        prdata[`IEEE_ADDR_LSB +: `IEEE_ADDR_W] <= bus_addr_r;
      end else if (hit_stat) begin
        prdata[`IEEE_ST_REMOTE] <= remote_r;
        prdata[`IEEE_ST_ADDRESSED] <= listen_r || talk_r;
        prdata[`IEEE_ST_LISTEN] <= listen_r;
        prdata[`IEEE_ST_TALK] <= talk_r;
        prdata[`IEEE_ST_LOCKOUT] <= lockout_r;
        prdata[`IEEE_ST_MEAS_LSB +: 2] <= meas_r;
      end else if (hit_meas) begin
        prdata[1:0] <= meas_r;
      end
    end
  end

  // Lamps follow the state directly.
  assign remote_lamp = remote_r;
  assign addressed_lamp = listen_r || talk_r;
  assign ac_level_lamp = (meas_r == `IEEE_MEAS_AC);
  assign sinad_lamp = (meas_r == `IEEE_MEAS_SINAD);
  assign distortion_lamp = (meas_r == `IEEE_MEAS_DIST);
  assign meas_select = meas_r;

endmodule

// *** verification/ieee_addr_properties.sv ***
// Purpose: Concurrent checks on the addressing block's ports.
// Assumes: Bus address stays 28 while bus bytes are sent.
// Notes: Talk checks assume no untalk arrives mid-message.
module ieee_addr_props (
  input wire pclk,
  input wire presetn,
  input wire ren,
  input wire atn,
  input wire bus_byte_valid,
  input wire [7:0] bus_byte_data,
  input wire local_key,
  input wire talk_take,
  input wire talk_valid,
  input wire [7:0] talk_data,
  input wire talk_last,
  input wire remote_lamp,
  input wire addressed_lamp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A command byte and its low seven bits.
  wire cmd = bus_byte_valid && atn;
  wire [6:0] c = bus_byte_data[6:0];
  wire ren_cmd = ren && cmd;
  a_own_listen: assert property (
    cmd && c == 7'h3C |=> addressed_lamp && remote_lamp == $past(ren))
    else $error("own listen address had the wrong effect");
  a_other_addr: assert property (
    cmd && c == 7'h2F |=> !addressed_lamp) else $error("other address kept addressed");
  a_remote_cause: assert property (
    $rose(remote_lamp) |-> $past(ren_cmd)) else $error("remote without REN and command");
  a_ren_false: assert property (
    !ren |=> !remote_lamp) else $error("remote stayed with REN false");
  a_key_addr: assert property (
    local_key && !bus_byte_valid |=> $stable(addressed_lamp))
    else $error("local key changed addressed state");
  a_talk_norem: assert property (
    cmd && c[6:5] == 2'h2 && !remote_lamp |=> !remote_lamp)
    else $error("talk address entered remote");
  a_talk_start: assert property (
    cmd && c == 7'h5C |-> ##12 !talk_valid ##1 talk_valid)
    else $error("first talk byte not at cycle 13");
  a_talk_hold: assert property (
    talk_valid && !talk_take |=> talk_valid && $stable(talk_data))
    else $error("talk byte dropped before take");
  a_take_gap: assert property (
    talk_valid && talk_take && !talk_last |=> !talk_valid ##1 talk_valid)
    else $error("talk gap not one cycle");
  a_last_lf: assert property (
    talk_valid && talk_last |-> talk_data == 8'h0A) else $error("last byte not LF");
endmodule

// *** verification/ieee_ctl_model.sv ***
// Purpose: Bus controller model on the far side of the block.
// Assumes: Bytes are handed over already handshaken, one pulse each.
// Notes: A released data line shows the inverse of the last byte.
module ieee_ctl (
  input wire pclk,
  input wire go,
  input wire talk_valid,
  input wire [7:0] talk_data,
  output logic ren = 1'b0,
  output logic atn = 1'b0,
  output logic bus_byte_valid = 1'b0,
  output logic [7:0] bus_byte_data = 8'h00,
  output logic talk_take = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx[$]; // Talk bytes taken so far.
  // Sends one byte; the strobe idles a cycle between bytes.
  task send(input logic a, input logic [7:0] d);
    @(posedge pclk);
    atn <= a;
    bus_byte_valid <= 1'b1;
    bus_byte_data <= d;
    @(posedge pclk);
    bus_byte_valid <= 1'b0;
    bus_byte_data <= ~d;
  endtask
  // REN may rise ahead of the listen address.
  task set_ren(input logic v);
    @(posedge pclk);
    ren <= v;
  endtask
  // Takes a shown byte only, stalling while go is low.
  always @(posedge pclk) begin
    if (talk_take && talk_valid) rx.push_back(talk_data);
    talk_take <= !talk_take && talk_valid && go;
  end
endmodule

// *** verification/tb.sv ***
// Purpose: Self-checking bench for the bus addressing block.
// Assumes: The controller model drives the bus side; the bench drives APB and keys.
// Notes: Integer model state holds the expected lamps and selection.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, sig_abs, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, q;
  logic [3:0] keys; // Local, AC level, SINAD, distortion.
  logic [19:0] mant, rm;
  logic [7:0] ex, re;
  logic [16:0] lf = 17'h12E0C, r;
  wire pready, pslverr, talk_valid, talk_last, ren, atn, bv, tt;
  wire rem_l, adr_l, ac_l, sin_l, dis_l;
  wire [31:0] prdata;
  wire [7:0] talk_data, bd;
  wire [1:0] meas;
  int mismatches = 0, n_tests = 0, cyc = 0, m_rem = 0, m_adr = 0, m_meas = 1;
  logic [7:0] exp_q[$];
  string s = "+90096E+05\n";
  ieee_addr i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .ren(ren), .atn(atn), .bus_byte_valid(bv), .bus_byte_data(bd),
    .talk_take(tt), .talk_valid(talk_valid), .talk_data(talk_data), .talk_last(talk_last),
    .local_key(keys[0]), .ac_level_key(keys[1]), .sinad_key(keys[2]),
    .distortion_select_key(keys[3]), .remote_lamp(rem_l), .addressed_lamp(adr_l),
    .ac_level_lamp(ac_l), .sinad_lamp(sin_l), .distortion_lamp(dis_l),
    .signal_absent(sig_abs), .result_mant(mant), .result_exp(ex), .meas_select(meas));
  ieee_ctl i_ctl (.pclk(pclk), .go(go), .talk_valid(talk_valid), .talk_data(talk_data),
    .ren(ren), .atn(atn), .bus_byte_valid(bv), .bus_byte_data(bd), .talk_take(tt));
  initial forever #4 pclk = ~pclk;
  function automatic logic [16:0] nx(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  // Random stall for the talker's partner, and a hang guard.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    lf <= nx(lf);
    go <= lf[0] | lf[3];
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  task chk(input string nm, input logic [31:0] x, input logic [31:0] v);
    n_tests++;
    if (v !== x) begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", nm, x, v);
    end
  endtask
  // Compares lamps and selection once the last change has landed.
  task st();
    @(posedge pclk);
    @(negedge pclk);
    chk("remote", m_rem, rem_l);
    chk("addressed", m_adr, adr_l);
    chk("meas", m_meas, meas);
    chk("sel_lamps", {m_meas == 3, m_meas == 2, m_meas == 1}, {dis_l, sin_l, ac_l});
  endtask
  // One APB transfer; waits for pready under a bound.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) mismatches++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task key(input int k);
    @(posedge pclk);
    keys <= 4'h1 << k;
    @(posedge pclk);
    keys <= 4'h0;
  endtask
  // Talk addressing, then compare every byte taken with the expected queue.
  task talk();
    int n;
    i_ctl.send(1'b1, 8'h5C);
    n = 0;
    while (i_ctl.rx.size() < 11 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk("talk_len", 11, i_ctl.rx.size());
    foreach (exp_q[i]) chk("talk_byte", exp_q[i], i_ctl.rx[i]);
    i_ctl.rx.delete();
    exp_q.delete();
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    paddr <= 12'h000;
    pwdata <= 32'h00000000;
    keys <= 4'h0;
    mant <= 20'h00000;
    ex <= 8'h00;
    sig_abs <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    st();
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h100, q);
    chk("pready", 1, pready);
    apb(1'b0, 12'h000, 32'h0);
    chk("cfg", 28, q[4:0]);
    apb(1'b1, 12'h000, 32'h5);
    apb(1'b0, 12'h000, 32'h0);
    chk("cfg_rw", 5, q[4:0]);
    apb(1'b0, 12'h00C, 32'h0);
    chk("slverr", 1, e);
    chk("unmapped", 0, q);
    apb(1'b1, 12'h000, 32'h1C);
    i_ctl.send(1'b1, 8'h3C);
    m_adr = 1;
    st();
    i_ctl.send(1'b1, 8'h2F);
    m_adr = 0;
    st();
    i_ctl.set_ren(1'b1);
    st();
    i_ctl.send(1'b1, 8'h3C);
    m_rem = 1;
    m_adr = 1;
    st();
    i_ctl.send(1'b1, 8'h01);
    m_rem = 0;
    st();
    i_ctl.send(1'b1, 8'h3C);
    m_rem = 1;
    key(0);
    m_rem = 0;
    st();
    i_ctl.send(1'b1, 8'h11);
    i_ctl.send(1'b1, 8'h3C);
    m_rem = 1;
    key(0);
    key(2);
    st();
    i_ctl.set_ren(1'b0);
    m_rem = 0;
    st();
    apb(1'b0, 12'h004, 32'h0);
    chk("status_low", 5'h06, q[4:0]);
    // Local selection keys, then each digit over the bus in remote.
    for (int k = 1; k < 4; k++) begin
      key(k);
      m_meas = k;
      st();
    end
    i_ctl.set_ren(1'b1);
    i_ctl.send(1'b1, 8'h3C);
    m_rem = 1;
    for (int k = 0; k < 3; k++) begin
      i_ctl.send(1'b0, 8'h4D);
      i_ctl.send(1'b0, 8'h30 + (k + 2) % 3 + 1);
      m_meas = (k + 2) % 3 + 1;
      st();
    end
    i_ctl.send(1'b1, 8'h14);
    m_meas = 1;
    st();
    apb(1'b0, 12'h008, 32'h0);
    chk("meas_reg", m_meas, q);
    // Distortion with no signal reports the error result.
    i_ctl.set_ren(1'b0);
    i_ctl.send(1'b1, 8'h3F);
    key(3);
    m_rem = 0;
    m_adr = 0;
    m_meas = 3;
    sig_abs <= 1'b1;
    for (int i = 0; i < s.len(); i++) exp_q.push_back(s[i]);
    talk();
    m_adr = 1;
    st();
    // Random result digits.
    i_ctl.send(1'b1, 8'h5F);
    r = lf;
    for (int i = 0; i < 7; i++) begin
      r = nx(r);
      if (i < 5) rm[4*i+:4] = r % 10;
      else re[4*(i-5)+:4] = r % 10;
    end
    @(posedge pclk);
    mant <= rm;
    ex <= re;
    sig_abs <= 1'b0;
    exp_q.push_back(8'h2B);
    for (int i = 4; i >= 0; i--) exp_q.push_back(8'h30 + rm[4*i+:4]);
    exp_q.push_back(8'h45);
    exp_q.push_back(8'h2B);
    exp_q.push_back(8'h30 + re[7:4]);
    exp_q.push_back(8'h30 + re[3:0]);
    exp_q.push_back(8'h0A);
    talk();
    print_verdict();
  end
endmodule
bind ieee_addr ieee_addr_props i_props (.pclk(pclk), .presetn(presetn), .ren(ren),
  .atn(atn), .bus_byte_valid(bus_byte_valid), .bus_byte_data(bus_byte_data),
  .local_key(local_key), .talk_take(talk_take), .talk_valid(talk_valid),
  .talk_data(talk_data), .talk_last(talk_last), .remote_lamp(remote_lamp),
  .addressed_lamp(addressed_lamp));
